// [bbbr_host_model.sv]
// host model: bit-level master for the serial register port
`timescale 1ns/1ps
module bbbr_host_model #(
	parameter logic [6:0] ADDR = 7'h36
) (
	// clock
	input  wire logic clock,
	// device pull-down enable
	input  wire logic sda_oe,
	// pin levels
	output logic      scl_pin,
	output logic      sda_pin
);
	logic sda_drv = 1'b1;
	// open drain with pull-up: low if either side pulls
	assign sda_pin = sda_drv & ~sda_oe;
	initial scl_pin = 1'b1;
	// 8-clock phases stay well clear of the device input filter
	task automatic lvl(input logic c, input logic d);
		scl_pin = c;
		sda_drv = d;
		repeat (8) @(negedge clock);
	endtask
	task automatic xbit(input logic b, output logic r);
		lvl(1'b0, b);
		lvl(1'b1, b);
		r = sda_pin;
		// data moves only two clocks after scl falls
		scl_pin = 1'b0;
		repeat (2) @(negedge clock);
	endtask
	task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
		xbit(m, a);
	endtask
	task automatic head(input logic [7:0] o, output logic a);
		logic [7:0] x;
		logic       a0;
		lvl(scl_pin, 1'b1);
		lvl(1'b1, 1'b1);
		lvl(1'b1, 1'b0);
		lvl(1'b0, 1'b0);
		xbyte({ADDR, 1'b0}, 1'b1, x, a0);
		xbyte(o, 1'b1, x, a);
		a = a | a0;
	endtask
	task automatic wr(input logic [7:0] o, input logic [7:0] d, output logic nak);
		logic [7:0] x;
		logic       a0, a1;
		head(o, a0);
		xbyte(d, 1'b1, x, a1);
		lvl(1'b0, 1'b0);
		lvl(1'b1, 1'b0);
		lvl(1'b1, 1'b1);
		nak = a0 | a1;
	endtask
	// single-byte read, closed by a master nack
	task automatic rd(input logic [7:0] o, output logic [7:0] q);
		logic [7:0] x;
		logic       a;
		head(o, a);
		lvl(1'b0, 1'b1);
		lvl(1'b1, 1'b1);
		lvl(1'b1, 1'b0);
		lvl(1'b0, 1'b0);
		xbyte({ADDR, 1'b1}, 1'b1, x, a);
		xbyte(8'hFF, 1'b1, q, a);
		lvl(1'b0, 1'b0);
		lvl(1'b1, 1'b0);
		lvl(1'b1, 1'b1);
	endtask
endmodule

// [bbbr_monitor.sv]
// checker: port-level timing of the register block
`timescale 1ns/1ps
module bbbr_monitor (
	// clock and reset
	input wire logic       clock,
	input wire logic       rst,
	// serial pins
	input wire logic       scl_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	// state and settings
	input wire logic       sleep_status,
	input wire logic [1:0] overvoltage_limit_sel,
	input wire logic [1:0] overcurrent_limit_sel,
	input wire logic       switch_freq_sel,
	input wire logic       freq_offset_en,
	input wire logic [7:0] bank_a_brightness,
	input wire logic [7:0] bank_b_brightness,
	input wire logic [4:0] bank_a_current,
	input wire logic [4:0] bank_b_current,
	input wire logic [7:0] pwm_code
);
	logic [9:0] gap_reg, gap_next;
	logic [7:0] code_reg;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// clocks since the sampler output last moved, saturating
	always_comb begin
		gap_next = (gap_reg == 10'h3FF) ? gap_reg : gap_reg + 10'h001;
		if (pwm_code != code_reg) gap_next = 10'h000;
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) {gap_reg, code_reg} <= 18'h00000;
		else {gap_reg, code_reg} <= {gap_next, pwm_code};
	end
	chk_sda_low_only: assert property (sda_out == 1'b0)
		else $error("sda_out drives high");
	chk_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("sda pulled while scl high");
	chk_brt_a_sleep: assert property (sleep_status |=> $stable(bank_a_brightness))
		else $error("bank a brightness moved in sleep");
	chk_brt_b_sleep: assert property (sleep_status |=> $stable(bank_b_brightness))
		else $error("bank b brightness moved in sleep");
	chk_boost_scl_low: assert property ($changed({overvoltage_limit_sel, overcurrent_limit_sel,
		switch_freq_sel, freq_offset_en}) |-> !scl_in) else $error("boost field moved off a write");
	chk_brt_scl_low: assert property ($changed({bank_a_brightness, bank_b_brightness})
		|-> !scl_in) else $error("brightness moved off a write");
	chk_cur_scl_low: assert property ($changed({bank_a_current, bank_b_current})
		|-> !scl_in) else $error("current moved off a write");
	chk_pwm_code_gap: assert property ($changed(pwm_code) |-> gap_reg >= 10'h1F4)
		else $error("sampler output moved within two windows");
	chk_oe_fall_scl: assert property ($fell(sda_oe) |-> !scl_in)
		else $error("sda released while scl high");
endmodule
bind bbbr_top bbbr_monitor i_mon (.clock(clock), .rst(rst), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .sleep_status(sleep_status),
	.overvoltage_limit_sel(overvoltage_limit_sel), .overcurrent_limit_sel(overcurrent_limit_sel),
	.switch_freq_sel(switch_freq_sel), .freq_offset_en(freq_offset_en),
	.bank_a_brightness(bank_a_brightness), .bank_b_brightness(bank_b_brightness),
	.bank_a_current(bank_a_current), .bank_b_current(bank_b_current), .pwm_code(pwm_code));

// [bbbr_pkg.sv]
// package: register map, field layout, reset values and sampler constants
package bbbr_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFS_BOOST = 8'h02;
	localparam logic [7:0] OFS_BRT_A = 8'h03;
	localparam logic [7:0] OFS_BRT_B = 8'h04;
	localparam logic [7:0] OFS_CUR_A = 8'h05;
	localparam logic [7:0] OFS_CUR_B = 8'h06;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [6:0] RST_BOOST   = 7'h38;
	localparam logic [7:0] RST_BRT     = 8'h00;
	localparam logic [4:0] RST_CUR     = 5'h1F;
	localparam logic [1:0] RST_CUR_CTL = 2'h0;

	// ****************************************
	// field positions
	// ****************************************
	localparam int OVP_HI    = 6;
	localparam int OVP_LO    = 5;
	localparam int OCP_HI    = 4;
	localparam int OCP_LO    = 3;
	localparam int SLOW_BIT  = 2;
	localparam int SHIFT_BIT = 1;
	localparam int FSEL_BIT  = 0;
	localparam int HYST_BIT  = 7;
	localparam int LB_BIT    = 6;
	localparam int CUR_HI    = 4;

	// ****************************************
	// pwm sampler and serial port constants
	// ****************************************
	localparam logic [1:0] HYST_OFF_CNT = 2'h3;
	localparam logic [1:0] HYST_ON_CNT  = 2'h2;
	localparam logic [7:0] LB_CODE      = 8'h06;
	localparam logic [7:0] LB_MIN       = 8'h02;
	localparam logic [7:0] PWM_WIN_LAST = 8'hFE;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ****************************************
	// serial port states
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b010,
		ST_RX   = 3'b011,
		ST_RACK = 3'b100,
		ST_TX   = 3'b101,
		ST_TACK = 3'b110
	} bbbr_st_t;

endpackage

// [bbbr_top.sv]
// top: serial register port, boost/bank configuration registers, pwm input sampler
`timescale 1ns/1ps
// Functional notes
// R1: overvoltage limit select in boost_setup bits 6:5, codes give 16/24/32/40 V.
// R2: overcurrent limit select in boost_setup bits 4:3, codes give 0.6/0.8/1/1.2 A.
// R3: bit 0 selects boost frequency, clear 500 kHz, set 1 MHz.
// R4: bit 1 set shifts boost frequency by about ten percent.
// R5: 8-bit brightness per bank at 0x03 and 0x04 drives that bank.
// R6: host must not program brightness below code 04h.
// R7: brightness writes are ignored while sleep status is active.
// R8: hysteresis clear: sampler output changes after three equal code changes.
// R9: hysteresis set: sampler output changes after two equal code changes.
// R10: lower bound clear: codes 2..6 give 6, codes 0..1 give 0.
// R11: lower bound set: sampler may output codes below 6.
// R12: bank A full-scale current in bits 4:0 of 0x05, reset 0x1F.
// R13: bank B full-scale current in bits 4:0 of 0x06.
// R14: sleep status input reflects sleep mode, one while asleep.
// R15: pwm input active low when polarity input is set, else high.
module bbbr_top #(
	parameter logic [6:0] SLAVE_ADDR = 7'h36
) (
	// clock, clock enable and reset
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       ce,
	// serial port pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// device state from control logic
	input  wire logic       sleep_status,
	input  wire logic       pwm_active_low,
	// pwm pin
	input  wire logic       pwm_in,
	// boost settings
	output logic [1:0]      overvoltage_limit_sel,
	output logic [1:0]      overcurrent_limit_sel,
	output logic            switch_freq_sel,
	output logic            freq_offset_en,
	output logic            slow_start_en,
	// bank settings
	output logic [7:0]      bank_a_brightness,
	output logic [7:0]      bank_b_brightness,
	output logic [4:0]      bank_a_current,
	output logic [4:0]      bank_b_current,
	// sampler result
	output logic [7:0]      pwm_code
);

	// ****************************************
	// parameter check
	// ****************************************
	generate
		if (SLAVE_ADDR[6:3] == 4'h0 || SLAVE_ADDR[6:3] == 4'hF) begin : g_bad_addr
			$error("slave address lies in a reserved range");
		end
	endgenerate

	// ****************************************
	// pin synchronisers and filters
	// ****************************************
	logic [2:0] s_scl_reg, s_sda_reg, s_pwm_reg;
	logic       f_scl_reg, f_sda_reg, f_pwm_reg, p_scl_reg, p_sda_reg;
	logic       f_scl_next, f_sda_next, f_pwm_next;

	// a change counts only once the second and third stages agree
	always_comb begin
		f_scl_next = (s_scl_reg[1] == s_scl_reg[2]) ? s_scl_reg[2] : f_scl_reg;
		f_sda_next = (s_sda_reg[1] == s_sda_reg[2]) ? s_sda_reg[2] : f_sda_reg;
		f_pwm_next = (s_pwm_reg[1] == s_pwm_reg[2]) ? s_pwm_reg[2] : f_pwm_reg;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_scl_reg <= 3'h7;
			s_sda_reg <= 3'h7;
			s_pwm_reg <= 3'h0;
			f_scl_reg <= 1'b1;
			f_sda_reg <= 1'b1;
			f_pwm_reg <= 1'b0;
			p_scl_reg <= 1'b1;
			p_sda_reg <= 1'b1;
		end else if (ce) begin
			s_scl_reg <= {s_scl_reg[1:0], scl_in};
			s_sda_reg <= {s_sda_reg[1:0], sda_in};
			s_pwm_reg <= {s_pwm_reg[1:0], pwm_in};
			f_scl_reg <= f_scl_next;
			f_sda_reg <= f_sda_next;
			f_pwm_reg <= f_pwm_next;
			p_scl_reg <= f_scl_reg;
			p_sda_reg <= f_sda_reg;
		end
	end

	logic scl_rise, scl_fall, start_cond, stop_cond;
	assign scl_rise   = f_scl_reg & ~p_scl_reg;
	assign scl_fall   = ~f_scl_reg & p_scl_reg;
	assign start_cond = f_scl_reg & p_scl_reg & p_sda_reg & ~f_sda_reg;
	assign stop_cond  = f_scl_reg & p_scl_reg & ~p_sda_reg & f_sda_reg;

	// ****************************************
	// registers
	// ****************************************
	logic [6:0] boost_reg, boost_next;
	logic [7:0] brt_a_reg, brt_a_next, brt_b_reg, brt_b_next;
	logic [1:0] cur_a_ctl_reg, cur_a_ctl_next;
	logic [4:0] cur_a_reg, cur_a_next, cur_b_reg, cur_b_next;
	logic [7:0] ptr_reg, ptr_next, sh_reg, sh_next, rd_byte;
	logic       wr_en;

	always_comb begin
		case (ptr_reg)
			bbbr_pkg::OFS_BOOST: rd_byte = {1'b0, boost_reg};
			bbbr_pkg::OFS_BRT_A: rd_byte = brt_a_reg;
			bbbr_pkg::OFS_BRT_B: rd_byte = brt_b_reg;
			bbbr_pkg::OFS_CUR_A: rd_byte = {cur_a_ctl_reg, 1'b0, cur_a_reg};
			bbbr_pkg::OFS_CUR_B: rd_byte = {3'h0, cur_b_reg};
			default:             rd_byte = 8'h00;
		endcase
	end

	// reserved bits are dropped on write and read back as zero
	always_comb begin
		boost_next     = boost_reg;
		brt_a_next     = brt_a_reg;
		brt_b_next     = brt_b_reg;
		cur_a_ctl_next = cur_a_ctl_reg;
		cur_a_next     = cur_a_reg;
		cur_b_next     = cur_b_reg;
		if (wr_en) begin
			case (ptr_reg)
				bbbr_pkg::OFS_BOOST: boost_next = sh_reg[6:0]; // R1 R2 R3 R4
				bbbr_pkg::OFS_BRT_A: begin
					if (!sleep_status) begin // R7 R14
						brt_a_next = sh_reg; // R5
					end
				end
				bbbr_pkg::OFS_BRT_B: begin
					if (!sleep_status) begin // R7 R14
						brt_b_next = sh_reg; // R5
					end
				end
				bbbr_pkg::OFS_CUR_A: begin
					cur_a_ctl_next = sh_reg[bbbr_pkg::HYST_BIT:bbbr_pkg::LB_BIT];
					cur_a_next     = sh_reg[bbbr_pkg::CUR_HI:0]; // R12
				end
				bbbr_pkg::OFS_CUR_B: cur_b_next = sh_reg[bbbr_pkg::CUR_HI:0]; // R13
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			boost_reg     <= bbbr_pkg::RST_BOOST;
			brt_a_reg     <= bbbr_pkg::RST_BRT;
			brt_b_reg     <= bbbr_pkg::RST_BRT;
			cur_a_ctl_reg <= bbbr_pkg::RST_CUR_CTL;
			cur_a_reg     <= bbbr_pkg::RST_CUR;
			cur_b_reg     <= bbbr_pkg::RST_CUR;
		end else if (ce) begin
			boost_reg     <= boost_next;
			brt_a_reg     <= brt_a_next;
			brt_b_reg     <= brt_b_next;
			cur_a_ctl_reg <= cur_a_ctl_next;
			cur_a_reg     <= cur_a_next;
			cur_b_reg     <= cur_b_next;
		end
	end

	// ****************************************
	// serial port slave
	// ****************************************
	bbbr_pkg::bbbr_st_t st_reg, st_next;
	logic [3:0] cnt_reg, cnt_next;
	logic       ptr_ok_reg, ptr_ok_next, rw_reg, rw_next, oe_reg, oe_next;

	always_comb begin
		st_next     = st_reg;
		cnt_next    = cnt_reg;
		sh_next     = sh_reg;
		ptr_next    = ptr_reg;
		ptr_ok_next = ptr_ok_reg;
		rw_next     = rw_reg;
		oe_next     = oe_reg;
		wr_en       = 1'b0;
		if (start_cond) begin
			st_next     = bbbr_pkg::ST_ADDR;
			cnt_next    = 4'h0;
			ptr_ok_next = 1'b0;
			oe_next     = 1'b0;
		end else if (stop_cond) begin
			st_next = bbbr_pkg::ST_IDLE;
			oe_next = 1'b0;
		end else begin
			case (st_reg)
				bbbr_pkg::ST_ADDR, bbbr_pkg::ST_RX: begin
					if (scl_rise) begin
						sh_next  = {sh_reg[6:0], f_sda_reg};
						cnt_next = cnt_reg + 4'h1;
					end else if (scl_fall && cnt_reg == bbbr_pkg::BITS_PER_BYTE) begin
						if (st_reg == bbbr_pkg::ST_RX) begin
							oe_next = 1'b1;
							st_next = bbbr_pkg::ST_RACK;
							if (ptr_ok_reg) begin
								wr_en    = 1'b1;
								ptr_next = ptr_reg + 8'h01;
							end else begin
								ptr_next    = sh_reg;
								ptr_ok_next = 1'b1;
							end
						end else if (sh_reg[7:1] == SLAVE_ADDR) begin
							oe_next = 1'b1;
							rw_next = sh_reg[0];
							st_next = bbbr_pkg::ST_AACK;
						end else begin
							st_next = bbbr_pkg::ST_IDLE;
						end
					end
				end
				bbbr_pkg::ST_AACK, bbbr_pkg::ST_RACK: begin
					if (scl_fall) begin
						cnt_next = 4'h0;
						if (st_reg == bbbr_pkg::ST_AACK && rw_reg) begin
							sh_next = rd_byte;
							oe_next = ~rd_byte[7];
							st_next = bbbr_pkg::ST_TX;
						end else begin
							oe_next = 1'b0;
							st_next = bbbr_pkg::ST_RX;
						end
					end
				end
				bbbr_pkg::ST_TX: begin
					if (scl_rise) begin
						cnt_next = cnt_reg + 4'h1;
					end else if (scl_fall) begin
						if (cnt_reg == bbbr_pkg::BITS_PER_BYTE) begin
							oe_next = 1'b0;
							st_next = bbbr_pkg::ST_TACK;
						end else begin
							sh_next = {sh_reg[6:0], 1'b0};
							oe_next = ~sh_reg[6];
						end
					end
				end
				bbbr_pkg::ST_TACK: begin
					// master nack ends the read; ack moves to the next register
					if (scl_rise) begin
						if (f_sda_reg) begin
							st_next = bbbr_pkg::ST_IDLE;
						end else begin
							ptr_next = ptr_reg + 8'h01;
						end
					end else if (scl_fall) begin
						cnt_next = 4'h0;
						sh_next  = rd_byte;
						oe_next  = ~rd_byte[7];
						st_next  = bbbr_pkg::ST_TX;
					end
				end
				default: st_next = bbbr_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_reg     <= bbbr_pkg::ST_IDLE;
			cnt_reg    <= 4'h0;
			sh_reg     <= 8'h00;
			ptr_reg    <= 8'h00;
			ptr_ok_reg <= 1'b0;
			rw_reg     <= 1'b0;
			oe_reg     <= 1'b0;
		end else if (ce) begin
			st_reg     <= st_next;
			cnt_reg    <= cnt_next;
			sh_reg     <= sh_next;
			ptr_reg    <= ptr_next;
			ptr_ok_reg <= ptr_ok_next;
			rw_reg     <= rw_next;
			oe_reg     <= oe_next;
		end
	end

	// ****************************************
	// pwm sampler
	// ****************************************
	logic [7:0] win_reg, win_next, hi_reg, hi_next, cand_reg, cand_next, code_reg, code_next;
	logic [7:0] eq_code, mapped;
	logic [1:0] cc_reg, cc_next, need;
	logic       act;

	// duty is measured over a fixed window; resolution traded for no divider
	always_comb begin
		act       = f_pwm_reg ^ pwm_active_low; // R15
		win_next  = win_reg + 8'h01;
		hi_next   = hi_reg + {7'h00, act};
		cand_next = cand_reg;
		cc_next   = cc_reg;
		code_next = code_reg;
		eq_code   = hi_reg + {7'h00, act};
		need      = cur_a_ctl_reg[1] ? bbbr_pkg::HYST_ON_CNT : bbbr_pkg::HYST_OFF_CNT; // R8 R9
		if (cur_a_ctl_reg[0]) begin
			mapped = eq_code; // R11
		end else if (eq_code < bbbr_pkg::LB_MIN) begin
			mapped = 8'h00; // R10
		end else if (eq_code <= bbbr_pkg::LB_CODE) begin
			mapped = bbbr_pkg::LB_CODE; // R10
		end else begin
			mapped = eq_code;
		end
		if (win_reg == bbbr_pkg::PWM_WIN_LAST) begin
			win_next = 8'h00;
			hi_next  = 8'h00;
			if (mapped == code_reg) begin
				cc_next = 2'h0;
			end else if (mapped == cand_reg && cc_reg != 2'h0) begin
				cc_next = (cc_reg == 2'h3) ? 2'h3 : cc_reg + 2'h1;
			end else begin
				cand_next = mapped;
				cc_next   = 2'h1;
			end
			if (cc_next >= need) begin // R8 R9
				code_next = mapped;
				cc_next   = 2'h0;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			win_reg  <= 8'h00;
			hi_reg   <= 8'h00;
			cand_reg <= 8'h00;
			cc_reg   <= 2'h0;
			code_reg <= 8'h00;
		end else if (ce) begin
			win_reg  <= win_next;
			hi_reg   <= hi_next;
			cand_reg <= cand_next;
			cc_reg   <= cc_next;
			code_reg <= code_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign sda_out               = 1'b0;
	assign sda_oe                = oe_reg;
	assign overvoltage_limit_sel = boost_reg[bbbr_pkg::OVP_HI:bbbr_pkg::OVP_LO]; // R1
	assign overcurrent_limit_sel = boost_reg[bbbr_pkg::OCP_HI:bbbr_pkg::OCP_LO]; // R2
	assign slow_start_en         = boost_reg[bbbr_pkg::SLOW_BIT];
	assign freq_offset_en        = boost_reg[bbbr_pkg::SHIFT_BIT]; // R4
	assign switch_freq_sel       = boost_reg[bbbr_pkg::FSEL_BIT]; // R3
	assign bank_a_brightness     = brt_a_reg; // R5
	assign bank_b_brightness     = brt_b_reg; // R5
	assign bank_a_current        = cur_a_reg; // R12
	assign bank_b_current        = cur_b_reg; // R13
	assign pwm_code              = code_reg;

endmodule

// [tb_bbbr_top.sv]
// testbench: register access, sleep lockout and pwm sampler
`timescale 1ns/1ps
module tb_bbbr_top;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       sleep = 1'b0;
	logic       act_low = 1'b0;
	logic       pwm_in = 1'b0;
	logic       ce = 1'b1;
	logic       scl, sda, sda_out, sda_oe, slw, fsh, fsel, nak;
	logic [1:0] ovp, ocp;
	logic [4:0] cur_a, cur_b;
	logic [7:0] brt_a, brt_b, code, q;
	int         err_total = 0;
	int         tests_run = 0;
	int         cycles = 0;
	int         duty = 0;
	int         pcnt = 0;
	bbbr_top i_dut (.clock(clock), .rst(rst), .ce(ce), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .sleep_status(sleep), .pwm_active_low(act_low),
		.pwm_in(pwm_in), .overvoltage_limit_sel(ovp), .overcurrent_limit_sel(ocp),
		.switch_freq_sel(fsel), .freq_offset_en(fsh), .slow_start_en(slw),
		.bank_a_brightness(brt_a), .bank_b_brightness(brt_b), .bank_a_current(cur_a),
		.bank_b_current(cur_b), .pwm_code(code));
	bbbr_host_model i_host (.clock(clock), .sda_oe(sda_oe), .scl_pin(scl), .sda_pin(sda));
	always #25 clock = ~clock;
	// period equals the 255-clock window, so each full window counts duty samples
	always @(negedge clock) begin
		pcnt <= (pcnt == 254) ? 0 : pcnt + 1;
		pwm_in <= (pcnt < duty);
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_total++;
			stop_test();
		end
	end
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		i_host.wr(o, d, nak);
		check("nak", {15'h0, nak}, 16'h0000);
	endtask
	task automatic rdc(input logic [7:0] o, input string nm, input logic [7:0] e);
		i_host.rd(o, q);
		check(nm, {8'h0, q}, {8'h0, e});
	endtask
	task automatic t_reset();
		check("boost", {9'h0, ovp, ocp, slw, fsh, fsel}, 16'h0038);
		check("brt", {brt_a, brt_b}, 16'h0000);
		check("cur", {3'h0, cur_a, 3'h0, cur_b}, 16'h1F1F);
		rdc(bbbr_pkg::OFS_CUR_A, "cur_a_rd", 8'h1F);
	endtask
	task automatic t_boost();
		logic [7:0] d [4] = '{8'h00, 8'hAA, 8'hD5, 8'hFF};
		foreach (d[i]) begin
			wr(bbbr_pkg::OFS_BOOST, d[i]);
			check("boost", {9'h0, ovp, ocp, slw, fsh, fsel}, {9'h0, d[i][6:0]});
		end
		rdc(bbbr_pkg::OFS_BOOST, "boost_rd", 8'h7F);
	endtask
	task automatic t_bright();
		wr(bbbr_pkg::OFS_BRT_A, 8'h55);
		wr(bbbr_pkg::OFS_BRT_B, 8'h04);
		check("brt", {brt_a, brt_b}, 16'h5504);
		sleep = 1'b1;
		wr(bbbr_pkg::OFS_BRT_A, 8'hC3);
		wr(bbbr_pkg::OFS_BRT_B, 8'hC3);
		check("brt_sleep", {brt_a, brt_b}, 16'h5504);
		rdc(bbbr_pkg::OFS_BRT_A, "brt_a_rd", 8'h55);
		sleep = 1'b0;
	endtask
	task automatic t_current();
		wr(bbbr_pkg::OFS_CUR_B, 8'hF3);
		rdc(bbbr_pkg::OFS_CUR_B, "cur_b_rd", 8'h13);
		wr(bbbr_pkg::OFS_CUR_A, 8'h2A);
		check("cur", {3'h0, cur_a, 3'h0, cur_b}, 16'h0A13);
		rdc(8'h30, "unmapped_rd", 8'h00);
	endtask
	// frozen port must neither acknowledge nor write
	task automatic t_hold();
		ce = 1'b0;
		i_host.wr(bbbr_pkg::OFS_BRT_B, 8'h40, nak);
		ce = 1'b1;
		check("hold_nak", {15'h0, nak}, 16'h0001);
		check("hold_brt", {brt_a, brt_b}, 16'h5504);
	endtask
	task automatic t_pwm();
		int t0;
		duty = 255;
		repeat (510) @(negedge clock);
		check("code_early", {8'h0, code}, 16'h0000);
		for (int i = 0; i < 1500 && code !== 8'hFF; i++) @(negedge clock);
		check("code_full", {8'h0, code}, 16'h00FF);
		t0 = cycles;
		wr(bbbr_pkg::OFS_CUR_A, 8'h8A);
		// flip polarity about 20 clocks before a window ends
		while ((cycles - t0) % 255 != 235) @(negedge clock);
		act_low = 1'b1;
		repeat (560) @(negedge clock);
		check("code_hyst", {8'h0, code}, 16'h0000);
	endtask
	task automatic t_bound();
		duty = 4;
		act_low = 1'b0;
		repeat (1100) @(negedge clock);
		check("code_floor", {8'h0, code}, 16'h0006);
		wr(bbbr_pkg::OFS_CUR_A, 8'hCA);
		repeat (800) @(negedge clock);
		check("code_low", {8'h0, code}, 16'h0004);
	endtask
	initial begin
		repeat (2) @(negedge clock);
		rst = 1'b0;
		repeat (4) @(negedge clock);
		t_reset();
		t_boost();
		t_bright();
		t_current();
		t_hold();
		t_pwm();
		t_bound();
		stop_test();
	end
endmodule
